// ### verilog/pfm_mux_consts.svh
// Constants for the port alternate-function mux: pin indices, masks, resets
// Assumes inclusion by the package only; pins are packed P0, P1, P3, P4
`ifndef PFM_MUX_CONSTS_SVH
`define PFM_MUX_CONSTS_SVH
`define PFM_P0_W 7
`define PFM_P1_W 2
`define PFM_P3_W 10
`define PFM_P4_W 1
`define PFM_NPINS 20
`define PFM_SYNC_STAGES 3
`define PFM_IX_T6_CH1 0
`define PFM_IX_T6_CH0 1
`define PFM_IX_NMI 2
`define PFM_IX_IRQ0 3
`define PFM_IX_IRQ1 4
`define PFM_IX_IRQ2 5
`define PFM_IX_IRQ3 6
`define PFM_IX_ANA0 7
`define PFM_IX_ANA1 8
`define PFM_IX_A0_TX 9
`define PFM_IX_A0_RX 10
`define PFM_IX_SCK4 11
`define PFM_IX_T0_CH1 12
`define PFM_IX_T1_CH0 13
`define PFM_IX_T1_CH1 14
`define PFM_IX_TW0_DATA 17
`define PFM_IX_TW0_CLK 18
`define PFM_IX_CS0 19
`define PFM_ALT_MASK 20'he7e7f
`define PFM_DBG_MASK 20'h00020
`define PFM_OE_N_RST 20'hfffff
`define PFM_LVL_RST 20'h00000
`endif

// ### verilog/pfm_mux_pkg.sv
// Types shared by the port alternate-function mux
// Assumes the constants header sits beside it
`include "pfm_mux_consts.svh"
package pfm_mux_pkg;
   typedef enum logic [1:0] {PFM_SCK_BAUD, PFM_SCK_SERIAL, PFM_SCK_CAPTURE, PFM_SCK_TIMER_OUT} pfm_p32_sel_t;
   typedef struct packed {
      logic [`PFM_NPINS-1:0] pad_out;
      logic [`PFM_NPINS-1:0] pad_oe_n;
      logic [`PFM_NPINS-1:0] level;
      logic [1:0]            cap6;
      logic                  nmi;
      logic [3:0]            ext_irq;
      logic                  adc_trig;
      logic                  dbg_rst;
      logic [1:0]            ana_en;
      logic                  a0_rx;
      logic                  irq7;
      logic                  cs4_din;
      logic                  a0_bclk;
      logic                  cs4_sck;
      logic [1:0]            cap0;
      logic [1:0]            cap1;
      logic                  a2_rx;
      logic                  tw0_data;
      logic                  tw0_clk;
      logic                  cs0_din;
      logic                  tw1_data;
   } pfm_state_t;
endpackage

// ### verilog/pfm_sync.sv
// Pin input synchroniser: three stages, change taken once stages two and three agree
// Assumes pins are asynchronous to core_clk
`timescale 1ns/1ps
module pfm_sync
   import pfm_mux_pkg::*;
#(
   parameter int W = `PFM_NPINS
)
(
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] pin_async,
   output logic      [W-1:0] pin_level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] filt;
   } pfm_sync_state_t;
   pfm_sync_state_t st_r;
   pfm_sync_state_t st_nxt;
   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.s1   = pin_async;
      st_nxt.s2   = st_r.s1;
      st_nxt.s3   = st_r.s2;
      st_nxt.filt = (st_r.s2 & ~(st_r.s2 ^ st_r.s3)) | (st_r.filt & (st_r.s2 ^ st_r.s3));
   end
   always_ff @(posedge core_clk)
   begin
      if (rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end
   assign pin_level = st_r.filt;
endmodule // pfm_sync

// ### verilog/pfm_pin_cell.sv
// One pin's output selector: port latch and direction, or alternate drive
// Assumes alt_* come from the mux decode on the same clock
`timescale 1ns/1ps
module pfm_pin_cell
(
   input  wire logic alt_sel,
   input  wire logic alt_drive,
   input  wire logic alt_val,
   input  wire logic alt_od,
   input  wire logic latch,
   input  wire logic dir,
   output logic      pad_out,
   output logic      pad_oe_n
);
   always_comb
   begin
      if (!alt_sel)
      begin
         pad_out  = latch;
         pad_oe_n = dir;
      end
      else if (alt_od)
      begin
         pad_out  = 1'b0;
         pad_oe_n = alt_val | ~alt_drive;
      end
      else
      begin
         pad_out  = alt_val;
         pad_oe_n = ~alt_drive;
      end
   end
endmodule // pfm_pin_cell

// ### verilog/pfm_mux.sv
// Port alternate-function mux for ports 0, 1, 3 and pin 0 of port 4
// Assumes control bits come from logic on core_clk; pad inputs are asynchronous
//
// Notes on behaviour
// - In alternate use, port latch and direction bits do not affect the pin.
// - P0 pin 0: capture input of timer6 ch1 at select 0, its output at 1.
// - P0 pin 1: capture input of timer6 ch0 at select 0, its output at 1.
// - P0 pin 2 feeds the non-maskable interrupt when its mode bit is set.
// - P0 pin 3: external interrupt 0 at select 0, converter trigger at 1.
// - P0 pins 4, 5, 6 feed external interrupts 1, 2, 3 in alternate mode.
// - Debug enable makes P0 pin 5 the debug reset, overriding mode and select.
// - P1 pins 0 and 1 give converter analog outputs when direction bit is 1.
// - P3 pin 0: async0 transmit at select 0, serial4 data out at 1.
// - P3 pin 1: async0 receive and interrupt 7 at 0, serial4 data in at 1.
// - P3 pin 2: baud clock, serial4 clock, timer0 ch0 capture or output.
// - P3 pin 3: timer0 ch1 capture at select 0, its output at 1.
// - P3 pins 4, 5: timer1 ch0, ch1 capture at select 0, outputs at 1.
// - P3 pin 8: async2 transmit at 0, two-wire 0 data at 1 with open drain.
// - P3 pin 9: async2 receive at 0, two-wire 0 clock at 1 with open drain.
// - P4 pin 0: serial0 data in at 0, two-wire 1 data at 1 with open drain.
// - Direction bit 0 means output, 1 means input, on every port pin.
`timescale 1ns/1ps
module pfm_mux
   import pfm_mux_pkg::*;
#(
   parameter int P0_W = `PFM_P0_W,
   parameter int P1_W = `PFM_P1_W,
   parameter int P3_W = `PFM_P3_W,
   parameter int P4_W = `PFM_P4_W
)
(
   input  wire logic            core_clk,
   input  wire logic            rst,
   input  wire logic [P0_W-1:0] p0_pin_function_mode_bit,
   input  wire logic [P0_W-1:0] p0_function_select_bit,
   input  wire logic [P0_W-1:0] p0_port_output_latch_bit,
   input  wire logic [P0_W-1:0] p0_direction_bit,
   input  wire logic [P1_W-1:0] p1_port_output_latch_bit,
   input  wire logic [P1_W-1:0] p1_direction_bit,
   input  wire logic [P3_W-1:0] p3_pin_function_mode_bit,
   input  wire logic [P3_W-1:0] p3_function_select_bit,
   input  wire logic [P3_W-1:0] p3_function_select_extension_bit,
   input  wire logic [P3_W-1:0] p3_port_output_latch_bit,
   input  wire logic [P3_W-1:0] p3_direction_bit,
   input  wire logic [P3_W-1:0] p3_open_drain_select_bit,
   input  wire logic [P4_W-1:0] p4_pin_function_mode_bit,
   input  wire logic [P4_W-1:0] p4_function_select_bit,
   input  wire logic [P4_W-1:0] p4_port_output_latch_bit,
   input  wire logic [P4_W-1:0] p4_direction_bit,
   input  wire logic [P4_W-1:0] p4_open_drain_select_bit,
   input  wire logic            debug_pin_enable,
   input  wire logic [P0_W-1:0] p0_pin_in,
   input  wire logic [P1_W-1:0] p1_pin_in,
   input  wire logic [P3_W-1:0] p3_pin_in,
   input  wire logic [P4_W-1:0] p4_pin_in,
   output logic      [P0_W-1:0] p0_pin_out,
   output logic      [P0_W-1:0] p0_pin_oe_n,
   output logic      [P1_W-1:0] p1_pin_out,
   output logic      [P1_W-1:0] p1_pin_oe_n,
   output logic      [P3_W-1:0] p3_pin_out,
   output logic      [P3_W-1:0] p3_pin_oe_n,
   output logic      [P4_W-1:0] p4_pin_out,
   output logic      [P4_W-1:0] p4_pin_oe_n,
   output logic      [P0_W-1:0] p0_pin_level,
   output logic      [P1_W-1:0] p1_pin_level,
   output logic      [P3_W-1:0] p3_pin_level,
   output logic      [P4_W-1:0] p4_pin_level,
   input  wire logic            timer6_out_ch1,
   input  wire logic            timer6_out_ch0,
   input  wire logic            async0_tx,
   input  wire logic            clocked_serial4_data_out,
   input  wire logic            clocked_serial4_clock_out,
   input  wire logic            clocked_serial4_clock_drive,
   input  wire logic            timer0_out_ch0,
   input  wire logic            timer0_out_ch1,
   input  wire logic            timer1_out_ch0,
   input  wire logic            timer1_out_ch1,
   input  wire logic            async2_tx,
   input  wire logic            twowire0_data_out,
   input  wire logic            twowire0_clock_out,
   input  wire logic            twowire1_data_out,
   output logic                 timer6_capture_in_ch1,
   output logic                 timer6_capture_in_ch0,
   output logic                 nmi_in,
   output logic                 ext_irq_in0,
   output logic                 ext_irq_in1,
   output logic                 ext_irq_in2,
   output logic                 ext_irq_in3,
   output logic                 converter_ext_trigger,
   output logic                 debug_reset_in,
   output logic                 analog_out0,
   output logic                 analog_out1,
   output logic                 async0_rx,
   output logic                 ext_irq_in7,
   output logic                 clocked_serial4_data_in,
   output logic                 async0_baud_clock_in,
   output logic                 clocked_serial4_clock_in,
   output logic                 timer0_capture_in_ch0,
   output logic                 timer0_capture_in_ch1,
   output logic                 timer1_capture_in_ch0,
   output logic                 timer1_capture_in_ch1,
   output logic                 async2_rx,
   output logic                 twowire0_data_in,
   output logic                 twowire0_clock_in,
   output logic                 clocked_serial0_data_in,
   output logic                 twowire1_data_in
);
   localparam int N = `PFM_NPINS;

   pfm_state_t   state_r;
   pfm_state_t   state_nxt;
   logic [N-1:0] mode_all;
   logic [N-1:0] fsel_all;
   logic [N-1:0] od_all;
   logic [N-1:0] latch_all;
   logic [N-1:0] dir_all;
   logic [N-1:0] pin_all;
   logic [N-1:0] lvl;
   logic [N-1:0] alt_sel;
   logic [N-1:0] alt_drive;
   logic [N-1:0] alt_val;
   logic [N-1:0] alt_od;
   logic [N-1:0] cell_out;
   logic [N-1:0] cell_oe_n;
   pfm_p32_sel_t sck_sel;

   // Flatten the ports into one pin vector
   assign mode_all  = {p4_pin_function_mode_bit, p3_pin_function_mode_bit, 2'h0, p0_pin_function_mode_bit};
   assign fsel_all  = {p4_function_select_bit, p3_function_select_bit, 2'h0, p0_function_select_bit};
   assign od_all    = {p4_open_drain_select_bit, p3_open_drain_select_bit, 9'h000};
   assign latch_all = {p4_port_output_latch_bit, p3_port_output_latch_bit, p1_port_output_latch_bit,
                       p0_port_output_latch_bit};
   assign dir_all   = {p4_direction_bit, p3_direction_bit, p1_direction_bit, p0_direction_bit};
   assign pin_all   = {p4_pin_in, p3_pin_in, p1_pin_in, p0_pin_in};

   assign sck_sel = pfm_p32_sel_t'({p3_function_select_extension_bit[2], p3_function_select_bit[2]});

   // Alternate selection, with debug overriding P0 pin 5
   assign alt_sel = (mode_all & `PFM_ALT_MASK) | (debug_pin_enable ? `PFM_DBG_MASK : 20'h00000);

   // Two-wire pins need both the select and the open-drain bit
   assign alt_od = {fsel_all[19] & od_all[19], fsel_all[18] & od_all[18], fsel_all[17] & od_all[17],
                    17'h00000};

   assign alt_drive = {alt_od[19],
                       alt_od[18],
                       ~fsel_all[17] | alt_od[17],
                       2'h0,
                       fsel_all[14], fsel_all[13],
                       fsel_all[12],
                       (sck_sel == PFM_SCK_SERIAL) ? clocked_serial4_clock_drive :
                                                     (sck_sel == PFM_SCK_TIMER_OUT),
                       1'b0,
                       1'b1,
                       7'h00,
                       fsel_all[1],
                       fsel_all[0]};

   assign alt_val = {twowire1_data_out,
                     twowire0_clock_out,
                     fsel_all[17] ? twowire0_data_out : async2_tx,
                     2'h0,
                     timer1_out_ch1, timer1_out_ch0,
                     timer0_out_ch1,
                     (sck_sel == PFM_SCK_SERIAL) ? clocked_serial4_clock_out : timer0_out_ch0,
                     1'b0,
                     fsel_all[9] ? clocked_serial4_data_out : async0_tx,
                     7'h00,
                     timer6_out_ch0,
                     timer6_out_ch1};

   pfm_sync #(
      .W         (N)
   ) u_sync (
      .core_clk  (core_clk),
      .rst       (rst),
      .pin_async (pin_all),
      .pin_level (lvl)
   );

   // Per-pin output selector
   genvar gi;
   generate
      for (gi = 0; gi < N; gi = gi + 1)
      begin : g_pin
         pfm_pin_cell u_cell (
            .alt_sel   (alt_sel[gi]),
            .alt_drive (alt_drive[gi]),
            .alt_val   (alt_val[gi]),
            .alt_od    (alt_od[gi]),
            .latch     (latch_all[gi]),
            .dir       (dir_all[gi]),
            .pad_out   (cell_out[gi]),
            .pad_oe_n  (cell_oe_n[gi])
         );
      end
   endgenerate

   always_comb
   begin
      state_nxt          = state_r;
      state_nxt.pad_out  = cell_out;
      state_nxt.pad_oe_n = cell_oe_n;
      state_nxt.level    = lvl;
      state_nxt.cap6[1]  = alt_sel[`PFM_IX_T6_CH1] & ~fsel_all[`PFM_IX_T6_CH1] & lvl[`PFM_IX_T6_CH1];
      state_nxt.cap6[0]  = alt_sel[`PFM_IX_T6_CH0] & ~fsel_all[`PFM_IX_T6_CH0] & lvl[`PFM_IX_T6_CH0];
      state_nxt.nmi      = alt_sel[`PFM_IX_NMI] & lvl[`PFM_IX_NMI];
      state_nxt.ext_irq[0] = alt_sel[`PFM_IX_IRQ0] & ~fsel_all[`PFM_IX_IRQ0] & lvl[`PFM_IX_IRQ0];
      state_nxt.adc_trig   = alt_sel[`PFM_IX_IRQ0] & fsel_all[`PFM_IX_IRQ0] & lvl[`PFM_IX_IRQ0];
      state_nxt.ext_irq[1] = alt_sel[`PFM_IX_IRQ1] & lvl[`PFM_IX_IRQ1];
      state_nxt.ext_irq[2] = ~debug_pin_enable & alt_sel[`PFM_IX_IRQ2] & lvl[`PFM_IX_IRQ2];
      state_nxt.ext_irq[3] = alt_sel[`PFM_IX_IRQ3] & lvl[`PFM_IX_IRQ3];
      state_nxt.dbg_rst    = debug_pin_enable & lvl[`PFM_IX_IRQ2];
      state_nxt.ana_en     = p1_direction_bit;
      state_nxt.a0_rx    = alt_sel[`PFM_IX_A0_RX] & ~fsel_all[`PFM_IX_A0_RX] & lvl[`PFM_IX_A0_RX];
      state_nxt.irq7     = alt_sel[`PFM_IX_A0_RX] & ~fsel_all[`PFM_IX_A0_RX] & lvl[`PFM_IX_A0_RX];
      state_nxt.cs4_din  = alt_sel[`PFM_IX_A0_RX] & fsel_all[`PFM_IX_A0_RX] & lvl[`PFM_IX_A0_RX];
      state_nxt.a0_bclk  = alt_sel[`PFM_IX_SCK4] & (sck_sel == PFM_SCK_BAUD) & lvl[`PFM_IX_SCK4];
      state_nxt.cs4_sck  = alt_sel[`PFM_IX_SCK4] & (sck_sel == PFM_SCK_SERIAL) & lvl[`PFM_IX_SCK4];
      state_nxt.cap0[0]  = alt_sel[`PFM_IX_SCK4] & (sck_sel == PFM_SCK_CAPTURE) & lvl[`PFM_IX_SCK4];
      state_nxt.cap0[1]  = alt_sel[`PFM_IX_T0_CH1] & ~fsel_all[`PFM_IX_T0_CH1] & lvl[`PFM_IX_T0_CH1];
      state_nxt.cap1[0]  = alt_sel[`PFM_IX_T1_CH0] & ~fsel_all[`PFM_IX_T1_CH0] & lvl[`PFM_IX_T1_CH0];
      state_nxt.cap1[1]  = alt_sel[`PFM_IX_T1_CH1] & ~fsel_all[`PFM_IX_T1_CH1] & lvl[`PFM_IX_T1_CH1];
      state_nxt.a2_rx    = alt_sel[`PFM_IX_TW0_CLK] & ~fsel_all[`PFM_IX_TW0_CLK] & lvl[`PFM_IX_TW0_CLK];
      state_nxt.tw0_data = alt_sel[`PFM_IX_TW0_DATA] & alt_od[`PFM_IX_TW0_DATA] & lvl[`PFM_IX_TW0_DATA];
      state_nxt.tw0_clk  = alt_sel[`PFM_IX_TW0_CLK] & alt_od[`PFM_IX_TW0_CLK] & lvl[`PFM_IX_TW0_CLK];
      state_nxt.cs0_din  = alt_sel[`PFM_IX_CS0] & ~fsel_all[`PFM_IX_CS0] & lvl[`PFM_IX_CS0];
      state_nxt.tw1_data = alt_sel[`PFM_IX_CS0] & alt_od[`PFM_IX_CS0] & lvl[`PFM_IX_CS0];
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_r          <= '0;
         state_r.pad_oe_n <= `PFM_OE_N_RST;
         state_r.level    <= `PFM_LVL_RST;
      end
      else
         state_r <= state_nxt;
   end

   // Registered outputs
   assign p0_pin_out   = state_r.pad_out[6:0];
   assign p0_pin_oe_n  = state_r.pad_oe_n[6:0];
   assign p1_pin_out   = state_r.pad_out[8:7];
   assign p1_pin_oe_n  = state_r.pad_oe_n[8:7];
   assign p3_pin_out   = state_r.pad_out[18:9];
   assign p3_pin_oe_n  = state_r.pad_oe_n[18:9];
   assign p4_pin_out   = state_r.pad_out[19:19];
   assign p4_pin_oe_n  = state_r.pad_oe_n[19:19];
   assign p0_pin_level = state_r.level[6:0];
   assign p1_pin_level = state_r.level[8:7];
   assign p3_pin_level = state_r.level[18:9];
   assign p4_pin_level = state_r.level[19:19];
   assign timer6_capture_in_ch1   = state_r.cap6[1];
   assign timer6_capture_in_ch0   = state_r.cap6[0];
   assign nmi_in                  = state_r.nmi;
   assign ext_irq_in0             = state_r.ext_irq[0];
   assign ext_irq_in1             = state_r.ext_irq[1];
   assign ext_irq_in2             = state_r.ext_irq[2];
   assign ext_irq_in3             = state_r.ext_irq[3];
   assign converter_ext_trigger   = state_r.adc_trig;
   assign debug_reset_in          = state_r.dbg_rst;
   assign analog_out0             = state_r.ana_en[0];
   assign analog_out1             = state_r.ana_en[1];
   assign async0_rx               = state_r.a0_rx;
   assign ext_irq_in7             = state_r.irq7;
   assign clocked_serial4_data_in = state_r.cs4_din;
   assign async0_baud_clock_in    = state_r.a0_bclk;
   assign clocked_serial4_clock_in = state_r.cs4_sck;
   assign timer0_capture_in_ch0   = state_r.cap0[0];
   assign timer0_capture_in_ch1   = state_r.cap0[1];
   assign timer1_capture_in_ch0   = state_r.cap1[0];
   assign timer1_capture_in_ch1   = state_r.cap1[1];
   assign async2_rx               = state_r.a2_rx;
   assign twowire0_data_in        = state_r.tw0_data;
   assign twowire0_clock_in       = state_r.tw0_clk;
   assign clocked_serial0_data_in = state_r.cs0_din;
   assign twowire1_data_in        = state_r.tw1_data;

   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   a_p00_timer_out: assert property (p0_pin_function_mode_bit[0] && p0_function_select_bit[0]
      |=> !p0_pin_oe_n[0] && p0_pin_out[0] == $past(timer6_out_ch1)) else $error("P00 timer out wrong");

   a_p01_capture: assert property (p0_pin_function_mode_bit[1] && !p0_function_select_bit[1]
      |=> p0_pin_oe_n[1] && timer6_capture_in_ch0 == $past(lvl[1])) else $error("P01 capture wrong");

   a_nmi_route: assert property ($past(p0_pin_function_mode_bit[2]) == 1'b0 |-> !nmi_in)
      else $error("NMI seen while pin in port mode");

   a_irq0_trigger: assert property (p0_pin_function_mode_bit[3] && p0_function_select_bit[3]
      |=> !ext_irq_in0 && converter_ext_trigger == $past(lvl[3])) else $error("P03 trigger wrong");

   a_irq_inputs: assert property (p0_pin_function_mode_bit[6] && p0_pin_function_mode_bit[4]
      |=> ext_irq_in3 == $past(lvl[6]) && ext_irq_in1 == $past(lvl[4])) else $error("IRQ route wrong");

   a_debug_reset: assert property (debug_pin_enable
      |=> p0_pin_oe_n[5] && !ext_irq_in2 && debug_reset_in == $past(lvl[5])) else $error("Debug reset wrong");

   a_analog_enable: assert property (1'b1 |=> analog_out0 == $past(p1_direction_bit[0]) &&
      analog_out1 == $past(p1_direction_bit[1])) else $error("Analog output wrong");

   a_p30_serial: assert property (p3_pin_function_mode_bit[0] && p3_function_select_bit[0]
      |=> !p3_pin_oe_n[0] && p3_pin_out[0] == $past(clocked_serial4_data_out)) else $error("P30 wrong");

   a_p31_rx_irq: assert property (p3_pin_function_mode_bit[1] && !p3_function_select_bit[1]
      |=> async0_rx == ext_irq_in7 && !clocked_serial4_data_in && p3_pin_oe_n[1]) else $error("P31 wrong");

   a_p32_timer: assert property (p3_pin_function_mode_bit[2] && sck_sel == PFM_SCK_TIMER_OUT
      |=> !p3_pin_oe_n[2] && p3_pin_out[2] == $past(timer0_out_ch0)) else $error("P32 timer out wrong");

   a_p33_p35_out: assert property (p3_pin_function_mode_bit[3] && p3_function_select_bit[3] &&
      p3_pin_function_mode_bit[5] && p3_function_select_bit[5] |=> p3_pin_out[3] == $past(timer0_out_ch1) &&
      p3_pin_out[5] == $past(timer1_out_ch1)) else $error("Timer outputs wrong");

   a_tw0_open_drain: assert property (p3_pin_function_mode_bit[8] && p3_function_select_bit[8] &&
      p3_open_drain_select_bit[8] |=> !p3_pin_out[8] && p3_pin_oe_n[8] == $past(twowire0_data_out))
      else $error("Two-wire data drive wrong");

   a_tw0_clock: assert property (p3_pin_function_mode_bit[9] && !p3_function_select_bit[9]
      |=> p3_pin_oe_n[9] && !twowire0_clock_in) else $error("P39 receive mode wrong");

   a_p40_tw1: assert property (p4_pin_function_mode_bit[0] && p4_function_select_bit[0] &&
      !p4_open_drain_select_bit[0] |=> p4_pin_oe_n[0] && !twowire1_data_in) else $error("P40 without open drain");

   a_general_port: assert property (!p0_pin_function_mode_bit[3]
      |=> p0_pin_out[3] == $past(p0_port_output_latch_bit[3]) && p0_pin_oe_n[3] == $past(p0_direction_bit[3]))
      else $error("General port pin wrong");

   a_p3_level: assert property (1'b1 |=> p3_pin_level == $past(lvl[18:9])) else $error("Level wrong");
endmodule // pfm_mux

// ### verif/pfm_periph_model.sv
// Peripheral-side model: timer, serial and two-wire outputs facing the mux
// Assumes the bench pulses step for one core_clk cycle to load a new pattern
`timescale 1ns/1ps
module pfm_periph_model
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        step,
   input  wire logic [13:0] pattern,
   output logic      [13:0] periph_out
);
   always_ff @(posedge core_clk)
   begin
      if (rst)
         periph_out <= 14'h0000;
      else if (step)
         periph_out <= pattern;
   end
endmodule // pfm_periph_model

// ### verif/tb_top.sv
// Bench for the port mux: random controls, pads and peripheral outputs
// Assumes the mux, its package and the peripheral model are compiled first
`timescale 1ns/1ps
module tb_top;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic step = 1'b0;
   logic debug_pin_enable;
   logic [6:0] p0_pin_function_mode_bit, p0_function_select_bit, p0_port_output_latch_bit, p0_direction_bit,
      p0_pin_in, p0_pin_out, p0_pin_oe_n, p0_pin_level;
   logic [1:0] p1_port_output_latch_bit, p1_direction_bit, p1_pin_in, p1_pin_out, p1_pin_oe_n, p1_pin_level;
   logic [9:0] p3_pin_function_mode_bit, p3_function_select_bit, p3_function_select_extension_bit,
      p3_port_output_latch_bit, p3_direction_bit, p3_open_drain_select_bit, p3_pin_in, p3_pin_out, p3_pin_oe_n,
      p3_pin_level;
   logic [0:0] p4_pin_function_mode_bit, p4_function_select_bit, p4_port_output_latch_bit, p4_direction_bit,
      p4_open_drain_select_bit, p4_pin_in, p4_pin_out, p4_pin_oe_n, p4_pin_level;
   logic timer6_out_ch1, timer6_out_ch0, async0_tx, clocked_serial4_data_out, clocked_serial4_clock_out,
      clocked_serial4_clock_drive, timer0_out_ch0, timer0_out_ch1, timer1_out_ch0, timer1_out_ch1, async2_tx,
      twowire0_data_out, twowire0_clock_out, twowire1_data_out;
   logic timer6_capture_in_ch1, timer6_capture_in_ch0, nmi_in, ext_irq_in0, ext_irq_in1, ext_irq_in2, ext_irq_in3,
      converter_ext_trigger, debug_reset_in, analog_out0, analog_out1, async0_rx, ext_irq_in7,
      clocked_serial4_data_in, async0_baud_clock_in, clocked_serial4_clock_in, timer0_capture_in_ch0,
      timer0_capture_in_ch1, timer1_capture_in_ch0, timer1_capture_in_ch1, async2_rx, twowire0_data_in,
      twowire0_clock_in, clocked_serial0_data_in, twowire1_data_in;
   logic [31:0]  seed = 32'hd6674212;
   logic [159:0] rv;
   logic [1:0]   sel;
   int           fails = 0;
   int           checks = 0;
   always #50 core_clk = ~core_clk;
   pfm_mux pfm_mux_inst (.*);
   pfm_periph_model pfm_periph_model_inst (.core_clk(core_clk), .rst(rst), .step(step), .pattern(rv[131:118]),
      .periph_out({timer6_out_ch1, timer6_out_ch0, async0_tx, clocked_serial4_data_out, clocked_serial4_clock_out,
      clocked_serial4_clock_drive, timer0_out_ch0, timer0_out_ch1, timer1_out_ch0, timer1_out_ch1, async2_tx,
      twowire0_data_out, twowire0_clock_out, twowire1_data_out}));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Expected {oe_n, out}: alternate drive or general port on direction and latch
   function automatic logic [1:0] pad(input logic mode, input logic drv, input logic alt, input logic dir,
      input logic lat);
      return mode ? {~drv, drv & alt} : {dir, ~dir & lat};
   endfunction
   task automatic chk(input string nm, input logic [1:0] e, input logic oe, input logic o);
      checks++;
      if ({oe, o & ~oe} !== e)
      begin
         fails++;
         $display("ERROR %s expected %b seen %b", nm, e, {oe, o & ~oe});
      end
   endtask
   task automatic drive(input logic [117:0] v);
      {debug_pin_enable, p0_pin_function_mode_bit, p0_function_select_bit, p0_port_output_latch_bit,
       p0_direction_bit, p0_pin_in, p1_port_output_latch_bit, p1_direction_bit, p1_pin_in, p3_pin_function_mode_bit,
       p3_function_select_bit, p3_function_select_extension_bit, p3_port_output_latch_bit, p3_direction_bit,
       p3_open_drain_select_bit, p3_pin_in, p4_pin_function_mode_bit, p4_function_select_bit,
       p4_port_output_latch_bit, p4_direction_bit, p4_open_drain_select_bit, p4_pin_in} <= v;
   endtask
   task automatic stop_test;
      $display("Counts: %0d checks, %0d fails", checks, fails);
      if (fails == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      #200000;
      fails++;
      stop_test();
   end
   initial
   begin
      rv = '0;
      drive(rv[117:0]);
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 0; i < 200; i++)
      begin
         @(posedge core_clk);
         for (int k = 0; k < 5; k++)
         begin
            seed = xs(seed);
            rv = {rv[127:0], seed};
         end
         // Corner: all port 0 pins alternate, debug enable toggling
         if (i < 8)
            rv[117:110] = {i[0], 7'h7f};
         // Keep the P1 latch bits when the two P1 direction bits differ
         if (^rv[79:78])
            rv[81:80] = p1_port_output_latch_bit;
         drive(rv[117:0]);
         step <= 1'b1;
         @(posedge core_clk);
         step <= 1'b0;
         repeat (5) @(posedge core_clk);
         #1;
         sel = {p3_function_select_extension_bit[2], p3_function_select_bit[2]};
         chk("p00", pad(p0_pin_function_mode_bit[0], p0_function_select_bit[0], timer6_out_ch1, p0_direction_bit[0],
             p0_port_output_latch_bit[0]), p0_pin_oe_n[0], p0_pin_out[0]);
         chk("p01", pad(p0_pin_function_mode_bit[1], p0_function_select_bit[1], timer6_out_ch0, p0_direction_bit[1],
             p0_port_output_latch_bit[1]), p0_pin_oe_n[1], p0_pin_out[1]);
         chk("p05", pad(p0_pin_function_mode_bit[5] | debug_pin_enable, 1'b0, 1'b0, p0_direction_bit[5],
             p0_port_output_latch_bit[5]), p0_pin_oe_n[5], p0_pin_out[5]);
         chk("p10", pad(1'b0, 1'b0, 1'b0, p1_direction_bit[0], p1_port_output_latch_bit[0]), p1_pin_oe_n[0],
             p1_pin_out[0]);
         chk("p30", pad(p3_pin_function_mode_bit[0], 1'b1, p3_function_select_bit[0] ? clocked_serial4_data_out :
             async0_tx, p3_direction_bit[0], p3_port_output_latch_bit[0]), p3_pin_oe_n[0], p3_pin_out[0]);
         chk("p32", pad(p3_pin_function_mode_bit[2], sel == 2'h3 || (sel == 2'h1 && clocked_serial4_clock_drive),
             sel == 2'h3 ? timer0_out_ch0 : clocked_serial4_clock_out, p3_direction_bit[2],
             p3_port_output_latch_bit[2]), p3_pin_oe_n[2], p3_pin_out[2]);
         chk("p34", pad(p3_pin_function_mode_bit[4], p3_function_select_bit[4], timer1_out_ch0, p3_direction_bit[4],
             p3_port_output_latch_bit[4]), p3_pin_oe_n[4], p3_pin_out[4]);
         chk("p38", pad(p3_pin_function_mode_bit[8], p3_function_select_bit[8] ? p3_open_drain_select_bit[8] &
             ~twowire0_data_out : 1'b1, ~p3_function_select_bit[8] & async2_tx, p3_direction_bit[8],
             p3_port_output_latch_bit[8]), p3_pin_oe_n[8], p3_pin_out[8]);
         chk("p40", pad(p4_pin_function_mode_bit[0], p4_function_select_bit[0] & p4_open_drain_select_bit[0] &
             ~twowire1_data_out, 1'b0, p4_direction_bit[0], p4_port_output_latch_bit[0]), p4_pin_oe_n[0],
             p4_pin_out[0]);
         chk("analog0", {1'b0, p1_direction_bit[0]}, 1'b0, analog_out0);
         chk("nmi", {1'b0, p0_pin_function_mode_bit[2] & p0_pin_in[2]}, 1'b0, nmi_in);
         chk("trig", {1'b0, p0_pin_function_mode_bit[3] & p0_function_select_bit[3] & p0_pin_in[3]}, 1'b0,
             converter_ext_trigger);
         chk("irq2", {1'b0, p0_pin_function_mode_bit[5] & ~debug_pin_enable & p0_pin_in[5]}, 1'b0,
             ext_irq_in2);
         chk("dbgrst", {1'b0, debug_pin_enable & p0_pin_in[5]}, 1'b0, debug_reset_in);
         chk("irq7", {1'b0, p3_pin_function_mode_bit[1] & ~p3_function_select_bit[1] & p3_pin_in[1]}, 1'b0,
             ext_irq_in7);
         chk("cap00", {1'b0, p3_pin_function_mode_bit[2] & (sel == 2'h2) & p3_pin_in[2]}, 1'b0,
             timer0_capture_in_ch0);
      end
      $display("Random mux sweep done");
      stop_test();
   end
endmodule // tb_top
